// *** cca_pkg.sv ***
// constants, types and helpers shared by the counter array design
// Notes on behaviour
// - One 16-bit time base counter is shared by all six capture/compare modules.
// - The time base tick comes from sysclk/12, sysclk/4, timer 0 overflow, external count input, sysclk or ext osc/8.
// - Each module runs edge capture, software timer, high-speed output or frequency output.
// - In PWM mode each module offers 8, 9, 10, 11 or 16 bit resolution.
// - Module 5 also acts as watchdog and comes out of every system reset enabled in that mode, unless software has locked it off.
// - Watchdog expiry raises a reset request, and software can switch that source off.
// - Software may lock the watchdog off after power-on reset; only the next power-on reset unlocks it.
// - Module pins and the external count input are presented for routing to port pins by the crossbar.
package cca_pkg;

    localparam int unsigned CCA_NUM_MODULES = 6;
    localparam int unsigned CCA_WIDTH       = 16;
    localparam int unsigned CCA_WDOG_MODULE = 5;

    localparam int unsigned CCA_SYS12_DIV = 12;
    localparam int unsigned CCA_SYS4_DIV  = 4;
    localparam int unsigned CCA_EXT8_DIV  = 8;

    localparam logic [15:0] CCA_COUNT_RESET      = 16'h0000;
    localparam logic [7:0]  CCA_WDOG_LIMIT_RESET = 8'hFF;
    localparam logic        CCA_WDOG_EN_RESET    = 1'b1;
    localparam logic        CCA_WDOG_LOCK_RESET  = 1'b0;

    typedef enum logic [2:0] {
        CCA_SRC_SYS12 = 3'b000,
        CCA_SRC_SYS4  = 3'b001,
        CCA_SRC_T0OVF = 3'b010,
        CCA_SRC_EXTIN = 3'b011,
        CCA_SRC_SYS   = 3'b100,
        CCA_SRC_EXT8  = 3'b101
    } cca_src_type;

    typedef enum logic [2:0] {
        CCA_MODE_OFF     = 3'b000,
        CCA_MODE_CAPTURE = 3'b001,
        CCA_MODE_SWTIMER = 3'b010,
        CCA_MODE_HSOUT   = 3'b011,
        CCA_MODE_PWM     = 3'b100,
        CCA_MODE_FREQ    = 3'b101
    } cca_mode_type;

    typedef enum logic [2:0] {
        CCA_PWM_8  = 3'b000,
        CCA_PWM_9  = 3'b001,
        CCA_PWM_10 = 3'b010,
        CCA_PWM_11 = 3'b011,
        CCA_PWM_16 = 3'b100
    } cca_pwm_type;

    function automatic logic [15:0] cca_pwm_mask(input cca_pwm_type w);
        logic [15:0] m;
        m = 16'h00FF;
        case (w)
            CCA_PWM_9:  m = 16'h01FF;
            CCA_PWM_10: m = 16'h03FF;
            CCA_PWM_11: m = 16'h07FF;
            CCA_PWM_16: m = 16'hFFFF;
            default:    m = 16'h00FF;
        endcase
        return m;
    endfunction

endpackage

// *** cca_cc_if.sv ***
// link between the time base and one capture/compare module
`timescale 1ns/100ps
interface cca_cc_if;
    import cca_pkg::*;
    logic         tick;
    logic [15:0]  count;
    cca_mode_type mode;
    logic         cap_rise;
    logic         cap_fall;
    logic [15:0]  cmp;
    cca_pwm_type  pwm_w;
    logic         pin;
    logic         pin_out;
    logic         pin_oe;
    logic         event_p;
    logic [15:0]  cap_val;

    modport ctrl (output tick, count, mode, cap_rise, cap_fall, cmp, pwm_w, pin,
                  input  pin_out, pin_oe, event_p, cap_val);
    modport unit (input  tick, count, mode, cap_rise, cap_fall, cmp, pwm_w, pin,
                  output pin_out, pin_oe, event_p, cap_val);
endinterface

// *** cca_cc_unit.sv ***
// one capture/compare module running off the shared time base
`timescale 1ns/100ps
module cca_cc_unit
    import cca_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_resetn,
    cca_cc_if.unit     cc
);

    logic        pin_prev_q, pin_prev_d;
    logic        out_q, out_d;
    logic        oe_q, oe_d;
    logic        evt_q, evt_d;
    logic [15:0] cap_q, cap_d;
    logic [7:0]  nxt_q, nxt_d;
    logic [15:0] mask;
    logic        rise;
    logic        fall;
    logic        match;

    always_comb begin
        mask       = cca_pwm_mask(cc.pwm_w);
        rise       = cc.pin & ~pin_prev_q;
        fall       = ~cc.pin & pin_prev_q;
        match      = cc.tick && (cc.count == cc.cmp);
        pin_prev_d = cc.pin;
        out_d      = out_q;
        cap_d      = cap_q;
        evt_d      = 1'b0;
        nxt_d      = cc.cmp[7:0];
        oe_d       = (cc.mode == CCA_MODE_HSOUT) || (cc.mode == CCA_MODE_PWM) ||
                     (cc.mode == CCA_MODE_FREQ);
        case (cc.mode)
            CCA_MODE_CAPTURE: begin
                // capture works between ticks too: the edge is the event
                if ((rise && cc.cap_rise) || (fall && cc.cap_fall)) begin
                    cap_d = cc.count;
                    evt_d = 1'b1;
                end
            end
            CCA_MODE_SWTIMER: begin
                evt_d = match;
            end
            CCA_MODE_HSOUT: begin
                if (match) begin
                    out_d = ~out_q;
                    evt_d = 1'b1;
                end
            end
            CCA_MODE_PWM: begin
                if (cc.tick) begin
                    // high while the masked count is below the duty value
                    out_d = (cc.count & mask) < (cc.cmp & mask);
                    evt_d = (cc.count & mask) == mask;
                end
            end
            CCA_MODE_FREQ: begin
                nxt_d = nxt_q;
                if (cc.tick && (cc.count[7:0] == nxt_q)) begin
                    out_d = ~out_q;
                    evt_d = 1'b1;
                    nxt_d = nxt_q + cc.cmp[7:0];
                end
            end
            default: begin
                out_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pin_prev_q <= 1'b0;
            out_q      <= 1'b0;
            oe_q       <= 1'b0;
            evt_q      <= 1'b0;
            cap_q      <= CCA_COUNT_RESET;
            nxt_q      <= CCA_COUNT_RESET[7:0];
        end else begin
            pin_prev_q <= pin_prev_d;
            out_q      <= out_d;
            oe_q       <= oe_d;
            evt_q      <= evt_d;
            cap_q      <= cap_d;
            nxt_q      <= nxt_d;
        end
    end

    assign cc.pin_out = out_q;
    assign cc.pin_oe  = oe_q;
    assign cc.event_p = evt_q;
    assign cc.cap_val = cap_q;

endmodule

// *** cca_counter_array.sv ***
// counter array: time base, clock select, watchdog and six compare modules
`timescale 1ns/100ps
module cca_counter_array
    import cca_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_por_resetn,
    input  wire logic         i_run,
    input  wire cca_src_type  i_clk_sel,
    input  wire logic         i_timer0_ovf,
    input  wire logic         i_external_count_input,
    input  wire logic         i_ext_osc,
    input  wire cca_pwm_type  i_pwm_width,
    input  wire cca_mode_type i_mode      [CCA_NUM_MODULES],
    input  wire logic         i_cap_rise  [CCA_NUM_MODULES],
    input  wire logic         i_cap_fall  [CCA_NUM_MODULES],
    input  wire logic [15:0]  i_cmp_val   [CCA_NUM_MODULES],
    input  wire logic [5:0]   i_cex_in,
    input  wire logic         i_wdog_kick,
    input  wire logic         i_wdog_disable,
    input  wire logic         i_wdog_lock,
    output logic [15:0]       o_count,
    output logic [5:0]        o_cex_out,
    output logic [5:0]        o_cex_oe,
    output logic [5:0]        o_event,
    output logic [15:0]       o_cap_val   [CCA_NUM_MODULES],
    output logic              o_wdog_enabled,
    output logic              o_wdog_reset
);

    // pin synchronisers: bits 5:0 module pins, 6 count input, 7 ext osc
    // pin edges reach the edge detectors two clocks after the pin moves, and take effect on the third
    logic [7:0]   sync1_q, sync1_d;
    logic [7:0]   sync2_q, sync2_d;
    logic         eci_prev_q, eci_prev_d;
    logic         osc_prev_q, osc_prev_d;
    logic [3:0]   div12_q, div12_d;
    logic [1:0]   div4_q, div4_d;
    logic [2:0]   div8_q, div8_d;
    logic [15:0]  count_q, count_d;
    logic         tick;
    logic         eci_edge;
    logic         osc_edge;
    logic         div12_wrap;
    logic         div4_wrap;
    logic         div8_wrap;
    logic         wd_en_q, wd_en_d;
    logic         wd_lock_q, wd_lock_d;
    logic [7:0]   wd_limit_q, wd_limit_d;
    logic         wd_rst_q, wd_rst_d;
    logic         wd_expire;
    logic         any_resetn;
    cca_mode_type mode_eff [CCA_NUM_MODULES];

    // either reset clears the time base and the modules
    assign any_resetn = i_resetn & i_por_resetn;

    // no reset on the synchroniser, pins are unrelated to reset release
    always_comb begin
        sync1_d = {i_ext_osc, i_external_count_input, i_cex_in};
        sync2_d = sync1_q;
    end

    always_ff @(posedge i_clk) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
    end

    // rising edges of the synchronised count input and oscillator
    always_comb begin
        eci_prev_d = sync2_q[6];
        osc_prev_d = sync2_q[7];
        eci_edge   = sync2_q[6] & ~eci_prev_q;
        osc_edge   = sync2_q[7] & ~osc_prev_q;
    end

    always_ff @(posedge i_clk) begin
        if (!any_resetn) begin
            eci_prev_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            eci_prev_q <= eci_prev_d;
            osc_prev_q <= osc_prev_d;
        end
    end

    // prescalers run free, so switching source never restarts them
    // the oscillator is sampled, so it must run well below i_clk
    always_comb begin
        div12_wrap = (div12_q == 4'(CCA_SYS12_DIV - 1));
        div4_wrap  = (div4_q == 2'(CCA_SYS4_DIV - 1));
        div8_wrap  = (div8_q == 3'(CCA_EXT8_DIV - 1));
        div12_d    = div12_wrap ? 4'h0 : div12_q + 4'h1;
        div4_d     = div4_q + 2'h1;
        div8_d     = osc_edge ? div8_q + 3'h1 : div8_q;
    end

    always_ff @(posedge i_clk) begin
        if (!any_resetn) begin
            div12_q <= 4'h0;
            div4_q  <= 2'h0;
            div8_q  <= 3'h0;
        end else begin
            div12_q <= div12_d;
            div4_q  <= div4_d;
            div8_q  <= div8_d;
        end
    end

    // a stopped time base gives no tick to any module
    always_comb begin
        // timer 0 overflow shares this clock and needs no synchroniser
        case (i_clk_sel)
            CCA_SRC_SYS12: tick = div12_wrap;
            CCA_SRC_SYS4:  tick = div4_wrap;
            CCA_SRC_T0OVF: tick = i_timer0_ovf;
            CCA_SRC_EXTIN: tick = eci_edge;
            CCA_SRC_SYS:   tick = 1'b1;
            CCA_SRC_EXT8:  tick = osc_edge && div8_wrap;
            default:       tick = 1'b0;
        endcase
        if (!i_run) begin
            tick = 1'b0;
        end
        // plain increment wraps 16'hFFFF to zero
        count_d = tick ? count_q + 16'h0001 : count_q;
    end

    always_ff @(posedge i_clk) begin
        if (!any_resetn) begin
            count_q <= CCA_COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // watchdog lock and enable
    // a lock pulse also clears the enable at once
    always_comb begin
        wd_lock_d = wd_lock_q | i_wdog_lock;
        wd_en_d   = wd_en_q & ~i_wdog_disable & ~i_wdog_lock;
    end

    always_ff @(posedge i_clk) begin
        if (!i_por_resetn) begin
            wd_lock_q <= CCA_WDOG_LOCK_RESET;
            wd_en_q   <= CCA_WDOG_EN_RESET;
        end else if (!i_resetn) begin
            // lock survives every reset except power-on
            wd_lock_q <= wd_lock_q;
            wd_en_q   <= ~wd_lock_q;
        end else begin
            wd_lock_q <= wd_lock_d;
            wd_en_q   <= wd_en_d;
        end
    end

    // watchdog limit and reset request
    // the limit holds only a high byte, with a low byte of zero, so the timeout moves in steps of 256 ticks
    always_comb begin
        wd_limit_d = wd_limit_q;
        if (i_wdog_kick) begin
            wd_limit_d = count_q[15:8] + i_cmp_val[CCA_WDOG_MODULE][15:8];
        end
        // expiry only on the tick taken while the count equals the limit byte and 00, so the request is one cycle
        wd_expire = tick && (count_q == {wd_limit_q, 8'h00});
        // kick wins over expiry in the same cycle, so a timely kick never resets
        wd_rst_d = wd_en_q && !i_wdog_kick && wd_expire;
    end

    always_ff @(posedge i_clk) begin
        if (!any_resetn) begin
            wd_limit_q <= CCA_WDOG_LIMIT_RESET;
            wd_rst_q   <= 1'b0;
        end else begin
            wd_limit_q <= wd_limit_d;
            wd_rst_q   <= wd_rst_d;
        end
    end

    // module 5 is held off while it serves as watchdog
    always_comb begin
        for (int m = 0; m < CCA_NUM_MODULES; m++) begin
            mode_eff[m] = i_mode[m];
        end
        if (wd_en_q) begin
            mode_eff[CCA_WDOG_MODULE] = CCA_MODE_OFF;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CCA_NUM_MODULES; g++) begin : gen_cc
            cca_cc_if cc ();
            assign cc.tick     = tick;
            assign cc.count    = count_q;
            assign cc.mode     = mode_eff[g];
            assign cc.cap_rise = i_cap_rise[g];
            assign cc.cap_fall = i_cap_fall[g];
            assign cc.cmp      = i_cmp_val[g];
            assign cc.pwm_w    = i_pwm_width;
            assign cc.pin      = sync2_q[g];
            // each module registers its own outputs
            cca_cc_unit u_unit (
                .i_clk    (i_clk),
                .i_resetn (any_resetn),
                .cc       (cc.unit)
            );
            assign o_cex_out[g] = cc.pin_out;
            assign o_cex_oe[g]  = cc.pin_oe;
            assign o_event[g]   = cc.event_p;
            assign o_cap_val[g] = cc.cap_val;
        end
    endgenerate

    assign o_count        = count_q;
    assign o_wdog_enabled = wd_en_q;
    assign o_wdog_reset   = wd_rst_q;

endmodule

// *** cca_counter_array_chk.sv ***
// port assertions for the counter array
`timescale 1ns/100ps
module cca_counter_array_chk
    import cca_pkg::*;
(
    input wire logic         i_clk,
    input wire logic         i_resetn,
    input wire logic         i_por_resetn,
    input wire logic         i_run,
    input wire cca_src_type  i_clk_sel,
    input wire cca_pwm_type  i_pwm_width,
    input wire cca_mode_type i_mode    [CCA_NUM_MODULES],
    input wire logic [15:0]  i_cmp_val [CCA_NUM_MODULES],
    input wire logic         i_wdog_lock,
    input wire logic [15:0]  o_count,
    input wire logic [5:0]   o_cex_out,
    input wire logic [5:0]   o_cex_oe,
    input wire logic [5:0]   o_event,
    input wire logic         o_wdog_enabled,
    input wire logic         o_wdog_reset
);
    logic tk;
    // only the undivided source gives a tick we can predict per cycle
    assign tk = i_run && (i_clk_sel == CCA_SRC_SYS);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!(i_resetn && i_por_resetn));
    AST_COUNT_STEP: assert property (tk |=> o_count == $past(o_count) + 16'h0001)
        else $error("count missed a tick");
    AST_COUNT_HOLD: assert property (!i_run |=> $stable(o_count))
        else $error("count moved while stopped");
    AST_HSOUT_EVT: assert property ((tk && i_mode[0] == CCA_MODE_HSOUT && o_count == i_cmp_val[0])
        |=> o_event[0] && (o_cex_out[0] != $past(o_cex_out[0])))
        else $error("high speed output missed match");
    AST_HSOUT_OE: assert property ((i_mode[0] == CCA_MODE_HSOUT) |=> o_cex_oe[0])
        else $error("pin not driven");
    AST_PWM8: assert property ((tk && i_mode[1] == CCA_MODE_PWM && i_pwm_width == CCA_PWM_8)
        |=> o_cex_out[1] == ($past(o_count[7:0]) < $past(i_cmp_val[1][7:0])))
        else $error("pwm level wrong");
    AST_M5_OFF: assert property (o_wdog_enabled |-> !o_cex_oe[5])
        else $error("module 5 drives pin in watchdog mode");
    AST_WDOG_PULSE: assert property (o_wdog_reset |=> !o_wdog_reset)
        else $error("reset request too long");
    AST_WDOG_SRC: assert property (o_wdog_reset |-> $past(o_wdog_enabled))
        else $error("reset request while disabled");
    AST_LOCK: assert property (@(posedge i_clk) disable iff (!i_por_resetn)
        i_wdog_lock |=> !o_wdog_enabled [*8])
        else $error("watchdog back on after lock");
    cover property (o_wdog_reset);
    cover property (o_event[0]);
    cover property (tk && o_count == 16'hFFFF);
endmodule

bind cca_counter_array cca_counter_array_chk i_chk (.i_clk, .i_resetn, .i_por_resetn, .i_run,
    .i_clk_sel, .i_pwm_width, .i_mode, .i_cmp_val, .i_wdog_lock, .o_count, .o_cex_out,
    .o_cex_oe, .o_event, .o_wdog_enabled, .o_wdog_reset);

// *** cca_counter_array_tb_top.sv ***
// self-checking bench for the counter array
`timescale 1ns/100ps
module cca_counter_array_tb_top
    import cca_pkg::*;
;
    logic         i_clk, i_resetn, i_por_resetn, i_run, i_timer0_ovf, i_external_count_input;
    logic         i_ext_osc, i_wdog_kick, i_wdog_disable, i_wdog_lock, o_wdog_enabled, o_wdog_reset;
    cca_src_type  i_clk_sel;
    cca_pwm_type  i_pwm_width;
    cca_mode_type i_mode    [CCA_NUM_MODULES];
    logic         i_cap_rise[CCA_NUM_MODULES], i_cap_fall[CCA_NUM_MODULES];
    logic [15:0]  i_cmp_val [CCA_NUM_MODULES], o_cap_val[CCA_NUM_MODULES];
    logic [5:0]   i_cex_in, o_cex_out, o_cex_oe, o_event;
    logic [15:0]  o_count, c0;
    int           n_fail, n_checks, k;

    cca_counter_array i_dut (.i_clk, .i_resetn, .i_por_resetn, .i_run, .i_clk_sel, .i_timer0_ovf,
        .i_external_count_input, .i_ext_osc, .i_pwm_width, .i_mode, .i_cap_rise, .i_cap_fall,
        .i_cmp_val, .i_cex_in, .i_wdog_kick, .i_wdog_disable, .i_wdog_lock, .o_count, .o_cex_out,
        .o_cex_oe, .o_event, .o_cap_val, .o_wdog_enabled, .o_wdog_reset);

    initial begin
        i_clk = 0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic wrap_up();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic step(input int n = 1);
        repeat (n) @(posedge i_clk);
        #10;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // expected pwm level for the count before the last edge, duty 0080
    function automatic logic pwm_exp(input int w, input logic [15:0] cnt);
        logic [15:0] m;
        m = (w == 4) ? 16'hFFFF : 16'((17'h1 << (w + 8)) - 1);
        return ((cnt - 16'h0001) & m) < (16'h0080 & m);
    endfunction

    task automatic tmo(input int i, input int lim);
        if (i >= lim) begin
            n_fail++;
            wrap_up();
        end
    endtask

    task automatic rst(input logic por);
        i_run = 0;
        i_resetn = 0;
        i_por_resetn = !por;
        step(12);
        chk(o_count, 16'h0000);
        i_resetn = 1;
        i_por_resetn = 1;
        step();
    endtask

    // async sources get 6 cycles a pulse to clear the synchroniser
    task automatic t_src(input cca_src_type s, input int n, input int per, input logic [15:0] d);
        i_clk_sel = s;
        c0 = o_count;
        i_run = 1;
        repeat (n) begin
            i_timer0_ovf = (s == CCA_SRC_T0OVF);
            i_external_count_input = (s == CCA_SRC_EXTIN);
            i_ext_osc = (s == CCA_SRC_EXT8);
            step();
            {i_timer0_ovf, i_external_count_input, i_ext_osc} = 3'h0;
            if (per > 1) step(per - 1);
        end
        i_run = 0;
        step(3);
        chk(o_count - c0, d);
    endtask

    task automatic t_wdog();
        chk(o_wdog_enabled, 1'b1);
        i_mode[5] = CCA_MODE_HSOUT;
        i_cmp_val[5] = 16'h0200;
        i_clk_sel = CCA_SRC_SYS;
        i_run = 1;
        step(5);
        c0 = o_count;
        i_wdog_kick = 1;
        step();
        i_wdog_kick = 0;
        for (k = 0; k < 1000 && o_wdog_reset !== 1'b1; k++) step();
        tmo(k, 1000);
        chk(o_count[15:8], c0[15:8] + 8'h02);
        chk(o_cex_oe[5], 1'b0);
        i_wdog_disable = 1;
        step();
        i_wdog_disable = 0;
        step();
        chk(o_wdog_enabled, 1'b0);
        chk(o_cex_oe[5], 1'b1);
        c0 = 0;
        repeat (600) begin
            step();
            c0 += o_wdog_reset;
        end
        chk(c0, 16'h0000);
        rst(1'b0);
        chk(o_wdog_enabled, 1'b1);
        i_wdog_lock = 1;
        step();
        i_wdog_lock = 0;
        rst(1'b0);
        chk(o_wdog_enabled, 1'b0);
        rst(1'b1);
        chk(o_wdog_enabled, 1'b1);
    endtask

    // count is frozen at 000A here, so the capture value is known
    task automatic t_cap();
        i_mode[3] = CCA_MODE_CAPTURE;
        i_cap_rise[3] = 1;
        step();
        i_cex_in[3] = 1;
        for (k = 0; k < 10 && o_event[3] !== 1'b1; k++) step();
        tmo(k, 10);
        chk(o_cap_val[3], 16'h000A);
        i_cap_rise[3] = 0;
        i_cap_fall[3] = 1;
        i_cex_in[3] = 0;
        step();
        for (k = 0; k < 10 && o_event[3] !== 1'b1; k++) step();
        tmo(k, 10);
        chk(16'(k), 16'h0002);
        chk(o_cap_val[3], 16'h000A);
    endtask

    task automatic t_modes();
        i_cmp_val[0] = 16'h000F;
        i_cmp_val[2] = 16'h000F;
        i_cmp_val[1] = 16'h0080;
        i_mode[0] = CCA_MODE_HSOUT;
        i_mode[1] = CCA_MODE_PWM;
        i_mode[2] = CCA_MODE_SWTIMER;
        i_mode[4] = CCA_MODE_FREQ;
        i_run = 1;
        for (k = 0; k < 20 && o_event[0] !== 1'b1; k++) step();
        tmo(k, 20);
        chk(o_count, 16'h0010);
        chk(o_event[2], 1'b1);
        chk(o_cex_oe, 6'h13);
        for (k = 0; k < 5; k++) begin
            i_pwm_width = cca_pwm_type'(k[2:0]);
            step(40);
            chk(o_cex_out[1], pwm_exp(k, o_count));
        end
    endtask

    initial begin
        n_fail = 0;
        n_checks = 0;
        {i_timer0_ovf, i_external_count_input, i_ext_osc} = 3'h0;
        {i_wdog_kick, i_wdog_disable, i_wdog_lock} = 3'h0;
        i_clk_sel = CCA_SRC_SYS;
        i_pwm_width = CCA_PWM_8;
        i_cex_in = 6'h00;
        for (k = 0; k < CCA_NUM_MODULES; k++) begin
            i_mode[k] = CCA_MODE_OFF;
            i_cap_rise[k] = 0;
            i_cap_fall[k] = 0;
            i_cmp_val[k] = 16'h0000;
        end
        rst(1'b1);
        t_wdog();
        t_src(CCA_SRC_SYS, 10, 1, 16'h000A);
        t_cap();
        t_modes();
        t_src(CCA_SRC_SYS12, 4, 12, 16'h0004);
        t_src(CCA_SRC_SYS4, 12, 4, 16'h000C);
        t_src(CCA_SRC_T0OVF, 5, 6, 16'h0005);
        t_src(CCA_SRC_EXTIN, 3, 6, 16'h0003);
        t_src(CCA_SRC_EXT8, 16, 6, 16'h0002);
        t_src(CCA_SRC_SYS, 1, 65536, 16'h0000);
        wrap_up();
    end
endmodule
